// [pcps_pkg.sv]
// Shared constants for the parallel capture port and its status logic.
// Assumes a 32-bit APB slave port; register byte address is four times its index.
package pcps_pkg;

   // ==========================================================
   // Register indices and byte addresses
   localparam logic [15:0] PULLUP_IDX = 16'h247d;
   localparam logic [15:0] STATUS_IDX = 16'h24b8;
   localparam logic [15:0] PORT_CTL_IDX = 16'h24b0;
   localparam logic [15:0] CAP_CTL_IDX = 16'h24b1;
   localparam logic [15:0] PULLUP_ADDR = 16'(PULLUP_IDX * 4);
   localparam logic [15:0] STATUS_ADDR = 16'(STATUS_IDX * 4);
   localparam logic [15:0] PORT_CTL_ADDR = 16'(PORT_CTL_IDX * 4);
   localparam logic [15:0] CAP_CTL_ADDR = 16'(CAP_CTL_IDX * 4);

   // ==========================================================
   // Capture control fields
   localparam int MASK_MSB = 19;
   localparam int PORT_SEL_BIT = 26;
   localparam int PACK_LSB = 27;
   localparam int EDGE_BIT = 29;
   localparam int FLUSH_BIT = 30;
   localparam int CAP_EN_BIT = 31;

   // ==========================================================
   // Input port control fields
   localparam int DMA_EN_BIT = 5;
   localparam int OVF_CLR_BIT = 6;

   // ==========================================================
   // Status fields
   localparam int MISC_MSB = 11;
   localparam int ACTIVE_LSB = 17;
   localparam int OVF_BIT = 25;
   localparam int FILL_LSB = 28;

   // ==========================================================
   // Reset values and widths
   localparam logic [19:0] PULLUP_RST = 20'hfffff;
   localparam logic [19:0] MASK_RST = 20'h00000;
   localparam int NUM_CHAN = 8;
   localparam int SYNC_W = 49;

   // ==========================================================
   // Packing modes
   typedef enum logic [1:0] {
      PCPS_PACK_8 = 2'b00,
      PCPS_PACK_11_11_10 = 2'b01,
      PCPS_PACK_16 = 2'b10,
      PCPS_PACK_20 = 2'b11
   } pcps_pack_e;

   localparam logic [19:0] PIECE_MASK_8 = 20'h000ff;
   localparam logic [19:0] PIECE_MASK_10 = 20'h003ff;
   localparam logic [19:0] PIECE_MASK_11 = 20'h007ff;
   localparam logic [19:0] PIECE_MASK_16 = 20'h0ffff;
   localparam logic [19:0] PIECE_MASK_20 = 20'hfffff;

endpackage

// [pcps_sync.sv]
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes inputs change slowly relative to ref_clk_in.
`timescale 1ns/1ps
module pcps_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Levels
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);

   logic [W-1:0] meta_reg;

   // ==========================================================
   // First stage feeds only the second
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         meta_reg <= '0;
         q_out <= '0;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end

endmodule

// [pcps_packer.sv]
// Packing unit: gathers parallel samples into 32-bit words.
// Assumes one-cycle sample strobes; flush drops any partial word.
`timescale 1ns/1ps
module pcps_packer (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Control
   input wire logic flush_in,
   input wire logic [1:0] mode_in,
   // Samples
   input wire logic sample_valid_in,
   input wire logic [19:0] sample_in,
   // Packed words
   output logic [31:0] word_out,
   output logic word_valid_out
);

   logic [31:0] acc_reg;
   logic [1:0] slot_reg;
   logic [1:0] last_slot;
   logic [4:0] shift;
   logic [19:0] piece_mask;
   logic [31:0] piece;

   // ==========================================================
   // Slot geometry per mode
   always_comb begin
      last_slot = 2'h0;
      shift = 5'h00;
      piece_mask = pcps_pkg::PIECE_MASK_20;
      case (pcps_pkg::pcps_pack_e'(mode_in))
         pcps_pkg::PCPS_PACK_8: begin
            last_slot = 2'h3;
            shift = {slot_reg, 3'h0};
            piece_mask = pcps_pkg::PIECE_MASK_8;
         end
         pcps_pkg::PCPS_PACK_11_11_10: begin
            last_slot = 2'h2;
            shift = (slot_reg == 2'h2) ? 5'h16 : ((slot_reg == 2'h1) ? 5'h0b : 5'h00);
            piece_mask = (slot_reg == 2'h2) ? pcps_pkg::PIECE_MASK_10 : pcps_pkg::PIECE_MASK_11;
         end
         pcps_pkg::PCPS_PACK_16: begin
            last_slot = 2'h1;
            shift = {slot_reg[0], 4'h0};
            piece_mask = pcps_pkg::PIECE_MASK_16;
         end
         default: begin
            last_slot = 2'h0;
            shift = 5'h00;
            piece_mask = pcps_pkg::PIECE_MASK_20;
         end
      endcase
      piece = {12'h000, sample_in & piece_mask} << shift;
   end

   // ==========================================================
   // Accumulate; flush zeros the partial word
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || flush_in) begin
         acc_reg <= 32'h00000000;
         slot_reg <= 2'h0;
         word_valid_out <= 1'b0;
      end else begin
         word_valid_out <= 1'b0;
         if (sample_valid_in) begin
            if (slot_reg >= last_slot) begin
               word_valid_out <= 1'b1;
               acc_reg <= 32'h00000000;
               slot_reg <= 2'h0;
            end else begin
               acc_reg <= acc_reg | piece;
               slot_reg <= slot_reg + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         word_out <= 32'h00000000;
      end else if (sample_valid_in && slot_reg >= last_slot && !flush_in) begin
         word_out <= acc_reg | piece;
      end
   end

endmodule

// [pcps_top.sv]
// Parallel capture port control, packing path, status and pull-up registers.
// Assumes an APB master on ref_clk_in; pins and capture clock are asynchronous;
// FIFO fill count, overflow and per-channel transfer-done come from logic on ref_clk_in.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps

// Contract
// - Capture control bits 19..0 hold one pass mask per parallel input pin.
// - A pin whose mask is zero contributes a zero bit to the sample.
// - Bit 26 selects upper 16 bits from address/data pins or audio pins 20..5.
// - Low four sample bits always come from audio pins 4..1.
// - Bits 28..27 choose packing: 8, 11/11/10, 16 or 20 bits into 32.
// - Bit 29 high latches on falling capture clock edge, low on rising.
// - Writing one to bit 30 strobes the packer flush once; bit reads zero.
// - The flush strobe zeros any partially packed word.
// - Bit 31 enables the selected pins as the parallel input channel.
// - While capture is enabled, channel 0 may not run as serial input.
// - Status bits 24..17 show per-channel transfer activity.
// - A channel's activity bit clears when its last transfer completes.
// - Setting the global transfer enable sets every channel's activity bit.
// - Status bit 25 is a sticky overflow flag.
// - Writing one to the write-only overflow clear bit clears the flag.
// - Status bits 31..28 show the FIFO sample count.
// - Status bits 11..0 show the live misc input states.
// - The status register is read-only; writes do not change it.
// - Pull-up register bits 19..0 enable each audio pin pull-up.
// - The pull-up register resets to all twenty bits set.
module pcps_top (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [15:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Parallel source pins
   input wire logic [19:0] audio_pins_in,
   input wire logic [15:0] ad_pins_in,
   input wire logic capture_clock_in,
   input wire logic [11:0] misc_input_state_in,
   // FIFO and transfer engine side
   input wire logic [3:0] queue_fill_count_in,
   input wire logic queue_overflow_in,
   input wire logic [7:0] channel_done_in,
   // Outputs to the FIFO, channel 0 and the pads
   output logic [31:0] packed_word_out,
   output logic packed_valid_out,
   output logic packer_flush_out,
   output logic channel0_serial_allow_out,
   output logic global_transfer_enable_out,
   output logic [19:0] pin_pullup_control_out
);

   // ==========================================================
   // Register state
   logic [19:0] pin_pullup_control_reg;
   logic [19:0] pin_capture_mask_reg;
   logic upper_pin_source_select_reg;
   logic [1:0] word_packing_mode_reg;
   logic capture_edge_select_reg;
   logic parallel_capture_enable_reg;
   logic packer_flush_reg;
   logic global_transfer_enable_reg;
   logic [7:0] channel_transfer_active_reg;
   logic queue_overflow_flag_reg;
   logic [31:0] prdata_reg;

   // ==========================================================
   // Bus decode
   logic setup_phase;
   logic access_phase;
   logic wr_en;
   logic hit_pullup;
   logic hit_status;
   logic hit_port_ctl;
   logic hit_cap_ctl;
   logic addr_hit;
   logic [31:0] rd_data;

   assign setup_phase = psel_in && !penable_in;
   assign access_phase = psel_in && penable_in;
   assign hit_pullup = (paddr_in == pcps_pkg::PULLUP_ADDR);
   assign hit_status = (paddr_in == pcps_pkg::STATUS_ADDR);
   assign hit_port_ctl = (paddr_in == pcps_pkg::PORT_CTL_ADDR);
   assign hit_cap_ctl = (paddr_in == pcps_pkg::CAP_CTL_ADDR);
   assign addr_hit = hit_pullup || hit_status || hit_port_ctl || hit_cap_ctl;
   assign wr_en = access_phase && pwrite_in;

   // Zero wait states; unmapped addresses answer with an error
   assign pready_out = access_phase;
   assign pslverr_out = access_phase && !addr_hit;
   assign prdata_out = prdata_reg;

   // ==========================================================
   // Pin synchronisers
   logic [pcps_pkg::SYNC_W-1:0] sync_d;
   logic [pcps_pkg::SYNC_W-1:0] sync_q;
   logic [19:0] audio_s;
   logic [15:0] ad_s;
   logic cap_clk_s;
   logic cap_clk_prev_reg;
   logic [11:0] misc_s;

   assign sync_d = {misc_input_state_in, capture_clock_in, ad_pins_in, audio_pins_in};
   assign audio_s = sync_q[19:0];
   assign ad_s = sync_q[35:20];
   assign cap_clk_s = sync_q[36];
   assign misc_s = sync_q[48:37];

   pcps_sync #(
      .W(pcps_pkg::SYNC_W)
   ) u_sync (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .d_in(sync_d),
      .q_out(sync_q)
   );

   // ==========================================================
   // Capture edge detection and sampling
   logic cap_rise;
   logic cap_fall;
   logic cap_edge;
   logic [19:0] raw_sample;
   logic [19:0] masked_sample;
   logic [19:0] sample_reg;
   logic sample_valid_reg;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cap_clk_prev_reg <= 1'b0;
      end else begin
         cap_clk_prev_reg <= cap_clk_s;
      end
   end

   assign cap_rise = cap_clk_s && !cap_clk_prev_reg;
   assign cap_fall = !cap_clk_s && cap_clk_prev_reg;
   assign cap_edge = capture_edge_select_reg ? cap_fall : cap_rise;

   // Upper source selection; low nibble is never multiplexed
   assign raw_sample[19:4] = upper_pin_source_select_reg ? ad_s : audio_s[19:4];
   assign raw_sample[3:0] = audio_s[3:0];
   assign masked_sample = raw_sample & pin_capture_mask_reg;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || packer_flush_reg) begin
         sample_reg <= 20'h00000;
         sample_valid_reg <= 1'b0;
      end else begin
         sample_valid_reg <= 1'b0;
         if (parallel_capture_enable_reg && cap_edge) begin
            sample_reg <= masked_sample;
            sample_valid_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Packing unit
   pcps_packer u_packer (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .flush_in(packer_flush_reg),
      .mode_in(word_packing_mode_reg),
      .sample_valid_in(sample_valid_reg),
      .sample_in(sample_reg),
      .word_out(packed_word_out),
      .word_valid_out(packed_valid_out)
   );

   // ==========================================================
   // Capture control register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pin_capture_mask_reg <= pcps_pkg::MASK_RST;
         upper_pin_source_select_reg <= 1'b0;
         word_packing_mode_reg <= 2'h0;
         capture_edge_select_reg <= 1'b0;
         parallel_capture_enable_reg <= 1'b0;
      end else if (wr_en && hit_cap_ctl) begin
         pin_capture_mask_reg <= pwdata_in[pcps_pkg::MASK_MSB:0];
         upper_pin_source_select_reg <= pwdata_in[pcps_pkg::PORT_SEL_BIT];
         word_packing_mode_reg <= pwdata_in[pcps_pkg::PACK_LSB+1:pcps_pkg::PACK_LSB];
         capture_edge_select_reg <= pwdata_in[pcps_pkg::EDGE_BIT];
         parallel_capture_enable_reg <= pwdata_in[pcps_pkg::CAP_EN_BIT];
      end
   end

   // Flush bit is a one-cycle strobe, never stored
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         packer_flush_reg <= 1'b0;
      end else begin
         packer_flush_reg <= wr_en && hit_cap_ctl && pwdata_in[pcps_pkg::FLUSH_BIT];
      end
   end

   assign packer_flush_out = packer_flush_reg;
   assign channel0_serial_allow_out = !parallel_capture_enable_reg;

   // ==========================================================
   // Input port control: transfer enable and overflow clear
   logic ovf_clear;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         global_transfer_enable_reg <= 1'b0;
      end else if (wr_en && hit_port_ctl) begin
         global_transfer_enable_reg <= pwdata_in[pcps_pkg::DMA_EN_BIT];
      end
   end

   assign global_transfer_enable_out = global_transfer_enable_reg;
   assign ovf_clear = wr_en && hit_port_ctl && pwdata_in[pcps_pkg::OVF_CLR_BIT];

   // ==========================================================
   // Channel activity; setting the enable wins over a done pulse
   logic dma_set;

   assign dma_set = wr_en && hit_port_ctl && pwdata_in[pcps_pkg::DMA_EN_BIT]
                    && !global_transfer_enable_reg;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         channel_transfer_active_reg <= 8'h00;
      end else if (dma_set) begin
         channel_transfer_active_reg <= 8'hff;
      end else begin
         channel_transfer_active_reg <= channel_transfer_active_reg & ~channel_done_in;
      end
   end

   // ==========================================================
   // Sticky overflow; a new overflow wins over the clear
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         queue_overflow_flag_reg <= 1'b0;
      end else if (queue_overflow_in) begin
         queue_overflow_flag_reg <= 1'b1;
      end else if (ovf_clear) begin
         queue_overflow_flag_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Pull-up register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pin_pullup_control_reg <= pcps_pkg::PULLUP_RST;
      end else if (wr_en && hit_pullup) begin
         pin_pullup_control_reg <= pwdata_in[19:0];
      end
   end

   assign pin_pullup_control_out = pin_pullup_control_reg;

   // ==========================================================
   // Read mux; reserved and write-only bits read zero
   always_comb begin
      rd_data = 32'h00000000;
      if (hit_cap_ctl) begin
         rd_data[pcps_pkg::MASK_MSB:0] = pin_capture_mask_reg;
         rd_data[pcps_pkg::PORT_SEL_BIT] = upper_pin_source_select_reg;
         rd_data[pcps_pkg::PACK_LSB+1:pcps_pkg::PACK_LSB] = word_packing_mode_reg;
         rd_data[pcps_pkg::EDGE_BIT] = capture_edge_select_reg;
         rd_data[pcps_pkg::CAP_EN_BIT] = parallel_capture_enable_reg;
      end else if (hit_status) begin
         rd_data[pcps_pkg::MISC_MSB:0] = misc_s;
         rd_data[pcps_pkg::ACTIVE_LSB+7:pcps_pkg::ACTIVE_LSB] = channel_transfer_active_reg;
         rd_data[pcps_pkg::OVF_BIT] = queue_overflow_flag_reg;
         rd_data[pcps_pkg::FILL_LSB+3:pcps_pkg::FILL_LSB] = queue_fill_count_in;
      end else if (hit_port_ctl) begin
         rd_data[pcps_pkg::DMA_EN_BIT] = global_transfer_enable_reg;
      end else if (hit_pullup) begin
         rd_data[19:0] = pin_pullup_control_reg;
      end
   end

   // Read data is captured in the setup cycle and stands through the access
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         prdata_reg <= 32'h00000000;
      end else if (setup_phase && !pwrite_in) begin
         prdata_reg <= rd_data;
      end
   end

   // ==========================================================
   // Checks
   sequence s_flush_write;
      wr_en && hit_cap_ctl && pwdata_in[pcps_pkg::FLUSH_BIT];
   endsequence

   sequence s_flush_strobe;
      packer_flush_reg ##1 !packer_flush_reg;
   endsequence

   a_flush_one_strobe: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_flush_write ##1 !(wr_en && hit_cap_ctl) |-> s_flush_strobe)
      else $error("flush strobe not a single pulse");

   a_flush_reads_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      access_phase && !pwrite_in && hit_cap_ctl |-> !prdata_out[pcps_pkg::FLUSH_BIT])
      else $error("flush bit read back nonzero");

   a_flush_empties_pack: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      packer_flush_reg |=> !packed_valid_out && !sample_valid_reg)
      else $error("data emerged right after flush");

   a_sample_masked: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      sample_valid_reg |-> (sample_reg & ~$past(pin_capture_mask_reg)) == 20'h00000)
      else $error("masked pin reached the sample");

   a_capture_gated: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !$past(parallel_capture_enable_reg) |-> !sample_valid_reg)
      else $error("sample taken while capture disabled");

   a_serial_blocked: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      parallel_capture_enable_reg |-> !channel0_serial_allow_out)
      else $error("channel 0 serial allowed during capture");

   a_dma_all_set: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      dma_set |=> channel_transfer_active_reg == 8'hff)
      else $error("activity bits not all set");

   a_dma_done_clears: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !dma_set && channel_done_in[0] |=> !channel_transfer_active_reg[0])
      else $error("activity bit held after done");

   a_ovf_sticky: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      queue_overflow_in ##1 !ovf_clear [*2] |-> queue_overflow_flag_reg)
      else $error("overflow flag lost");

   a_ovf_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ovf_clear && !queue_overflow_in |=> !queue_overflow_flag_reg)
      else $error("overflow flag not cleared");

   a_status_ro: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_en && hit_status && !queue_overflow_in |=> $stable(queue_overflow_flag_reg))
      else $error("status write changed flag");

   a_pullup_reset: assert property (@(posedge ref_clk_in)
      $past(rst_in) |-> pin_pullup_control_out == pcps_pkg::PULLUP_RST)
      else $error("pull-up reset value wrong");

endmodule

// [pcps_source.sv]
// Parallel source model: drives the capture pins and one capture clock period per sample.
// Assumes the bench pulses send_in for one ref_clk_in cycle and waits 16 cycles between sends.
`timescale 1ns/1ps
module pcps_source (
   // Clock
   input wire logic ref_clk_in,
   // Request
   input wire logic send_in,
   input wire logic [19:0] dai_in,
   input wire logic [15:0] ad_in,
   // Pins
   output logic [19:0] audio_pins_out,
   output logic [15:0] ad_pins_out,
   output logic capture_clock_out
);
   logic [3:0] step_reg;
   // ====
   // Data three cycles ahead of the rising edge, clock idle low between samples
   initial begin
      step_reg = 4'h0;
      audio_pins_out = 20'h00000;
      ad_pins_out = 16'h0000;
      capture_clock_out = 1'b0;
   end
   always @(posedge ref_clk_in) begin
      if (send_in && step_reg == 4'h0) begin
         audio_pins_out <= dai_in;
         ad_pins_out <= ad_in;
         step_reg <= 4'h1;
      end else if (step_reg != 4'h0) begin
         step_reg <= (step_reg == 4'he) ? 4'h0 : step_reg + 4'h1;
         capture_clock_out <= (step_reg >= 4'h3 && step_reg < 4'h7);
         // Hold time over: pins no longer show the sample
         if (step_reg == 4'he) begin
            audio_pins_out <= ~audio_pins_out;
            ad_pins_out <= ~ad_pins_out;
         end
      end
   end
endmodule

// [parallel_capture_port_status_bench.sv]
// Self-checking bench for the capture port: APB master, source model, status inputs.
// Assumes zero-wait APB as described for pcps_top.
`timescale 1ns/1ps
module parallel_capture_port_status_bench;
   localparam logic [15:0] CA = pcps_pkg::CAP_CTL_ADDR;
   localparam logic [15:0] PA = pcps_pkg::PULLUP_ADDR;
   localparam logic [15:0] SA = pcps_pkg::STATUS_ADDR;
   logic ref_clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic capture_clock_in, send, queue_overflow_in, packed_valid_out, packer_flush_out;
   logic channel0_serial_allow_out, global_transfer_enable_out, err;
   logic [15:0] paddr_in, ad_pins_in, s_ad;
   logic [19:0] audio_pins_in, pin_pullup_control_out, s_dai;
   logic [31:0] pwdata_in, prdata_out, packed_word_out, rd, last_word;
   logic [11:0] misc_input_state_in;
   logic [3:0] queue_fill_count_in;
   logic [7:0] channel_done_in;
   int n_errors, n_compared, n_valid, n_flush, cycles;
   typedef struct packed {logic [31:0] ctl; logic [19:0] dai; logic [15:0] ad; logic [31:0] w;}
      pcps_row_s;
   pcps_row_s rows [6];
   pcps_top pcps_top_inst (.ref_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .audio_pins_in, .ad_pins_in,
      .capture_clock_in, .misc_input_state_in, .queue_fill_count_in, .queue_overflow_in,
      .channel_done_in, .packed_word_out, .packed_valid_out, .packer_flush_out,
      .channel0_serial_allow_out, .global_transfer_enable_out, .pin_pullup_control_out);
   pcps_source pcps_source_inst (.ref_clk_in, .send_in(send), .dai_in(s_dai), .ad_in(s_ad),
      .audio_pins_out(audio_pins_in), .ad_pins_out(ad_pins_in),
      .capture_clock_out(capture_clock_in));
   // ====
   // Tasks
   task automatic summarize();
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge ref_clk_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic put(input logic [19:0] d, input logic [15:0] a);
      @(posedge ref_clk_in);
      s_dai <= d;
      s_ad <= a;
      send <= 1'b1;
      @(posedge ref_clk_in);
      send <= 1'b0;
      repeat (16) @(posedge ref_clk_in);
   endtask
   // ====
   // Clock, monitor, timeout
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cycles++;
      if (packed_valid_out === 1'b1) begin
         n_valid++;
         last_word = packed_word_out;
      end
      if (packer_flush_out === 1'b1) begin
         n_flush++;
      end
      if (cycles == 20000) begin
         n_errors++;
         summarize();
      end
   end
   // ====
   // Sequence
   initial begin
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, send, s_dai, s_ad} = '0;
      {misc_input_state_in, queue_fill_count_in, queue_overflow_in, channel_done_in} = '0;
      {n_errors, n_compared, n_valid, n_flush, cycles} = '0;
      rows[0] = {32'h800fffff, 20'habc12, 16'h0000, 32'h15141312};
      rows[1] = {32'h880fffff, 20'h00401, 16'h0000, 32'h00e01401};
      rows[2] = {32'h900fffff, 20'h51234, 16'h0000, 32'h12351234};
      rows[3] = {32'h980fffff, 20'h12345, 16'h0000, 32'h00012345};
      rows[4] = {32'hbc0fffff, 20'h00005, 16'habcd, 32'h000abcd5};
      rows[5] = {32'h980f0f0f, 20'hfffff, 16'h0000, 32'h000f0f0f};
      rst_in = 1'b1;
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd_chk(PA, 32'h000fffff);
      chk({31'h0, channel0_serial_allow_out}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         n_flush = 0;
         apb(1'b1, CA, rows[i].ctl | 32'h40000000);
         rd_chk(CA, rows[i].ctl);
         chk({31'h0, channel0_serial_allow_out}, 32'h0);
         n_valid = 0;
         for (int k = 0; k < 4 - rows[i].ctl[28:27]; k++) put(rows[i].dai + 20'(k), rows[i].ad);
         chk(32'(n_valid), 32'h1);
         chk(32'(n_flush), 32'h1);
         chk(last_word, rows[i].w);
      end
      apb(1'b1, CA, 32'h93ffffff);
      rd_chk(CA, 32'h900fffff);
      put(20'h0aaaa, 16'h0);
      apb(1'b1, CA, 32'hd00fffff);
      n_valid = 0;
      put(20'h01111, 16'h0);
      put(20'h02222, 16'h0);
      chk(32'(n_valid), 32'h1);
      chk(last_word, 32'h22221111);
      apb(1'b1, CA, 32'h180fffff);
      n_valid = 0;
      put(20'h12345, 16'h0);
      chk(32'(n_valid), 32'h0);
      apb(1'b1, PA, 32'hfff12345);
      rd_chk(PA, 32'h00012345);
      chk({12'h0, pin_pullup_control_out}, 32'h00012345);
      misc_input_state_in <= 12'ha5c;
      queue_fill_count_in <= 4'h9;
      queue_overflow_in <= 1'b1;
      @(posedge ref_clk_in);
      queue_overflow_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      rd_chk(SA, 32'h92000a5c);
      apb(1'b1, SA, 32'h0);
      rd_chk(SA, 32'h92000a5c);
      apb(1'b1, pcps_pkg::PORT_CTL_ADDR, 32'h00000060);
      rd_chk(SA, 32'h91fe0a5c);
      chk({31'h0, global_transfer_enable_out}, 32'h1);
      channel_done_in <= 8'h81;
      @(posedge ref_clk_in);
      channel_done_in <= 8'h00;
      rd_chk(SA, 32'h90fc0a5c);
      apb(1'b1, 16'h0010, 32'hffffffff);
      rd_chk(16'h0010, 32'h0);
      chk({31'h0, err}, 32'h1);
      @(posedge ref_clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd_chk(PA, 32'h000fffff);
      summarize();
   end
endmodule
